// >>> common/swk_pkg.sv
// package of constants and types for the sleep wake event logic
package swk_pkg;
   // sleep state encoding on the state input
   localparam logic [1:0] SWK_ST_S0 = 2'h0;
   localparam logic [1:0] SWK_ST_S3 = 2'h1;
   localparam logic [1:0] SWK_ST_S4 = 2'h2;
   localparam logic [1:0] SWK_ST_S5 = 2'h3;
   // wake source bit positions
   localparam int SWK_SRC_PWRBTN = 0;
   localparam int SWK_SRC_SMBALR = 1;
   localparam int SWK_SRC_PCIEWK = 2;
   localparam int SWK_SRC_WDTBTN = 3;
   localparam int SWK_SRC_GENWK = 4;
   localparam int SWK_SRC_PME = 5;
   localparam int SWK_SRC_LAN = 6;
   localparam int SWK_SRC_USB = 7;
   localparam int SWK_SRC_RTC = 8;
   localparam int SWK_NSRC = 9;
   // register offsets
   localparam logic [3:0] SWK_REG_CTRL = 4'h0;
   localparam logic [3:0] SWK_REG_STATUS = 4'h4;
   localparam logic [3:0] SWK_REG_MASK = 4'h8;
   localparam logic [3:0] SWK_REG_STATE = 4'hC;
   // control field positions
   localparam int SWK_CTL_PME_EN = 0;
   localparam int SWK_CTL_RTC_EN = 1;
   localparam int SWK_CTL_USB_EN = 2;
   localparam int SWK_CTL_USB_SBY = 3;
   localparam int SWK_CTL_LAN_EN = 4;
   localparam int SWK_CTL_W = 5;
   // reset values
   localparam logic [SWK_CTL_W-1:0] SWK_CTL_RST = 5'h00;
   localparam logic [SWK_NSRC-1:0] SWK_MASK_RST = 9'h000;
   // resume pulse length in cycles
   localparam int SWK_RESUME_CYC = 1;
   // sequencer states, gray along the usual path
   typedef enum logic [1:0] {
      SWK_IDLE = 2'b00,
      SWK_ARMED = 2'b01,
      SWK_RESUME = 2'b11,
      SWK_WAIT = 2'b10
   } swk_state_e;
endpackage : swk_pkg

// >>> common/swk_wake_if.sv
// interface carrying synchronised wake levels between sync and core
`timescale 1ns/100ps
interface swk_wake_if;
   import swk_pkg::*;
   logic [SWK_NSRC-1:0] level;
   modport src (output level);
   modport dst (input level);
endinterface : swk_wake_if

// >>> src/swk_sync.sv
// two-flop synchroniser and polarity fix for all wake pins
`timescale 1ns/100ps
module swk_sync
   import swk_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [SWK_NSRC-1:0] raw_i,
   input wire logic [SWK_NSRC-1:0] act_low_i,
   swk_wake_if.src wake
);
   logic [SWK_NSRC-1:0] meta;
   logic [SWK_NSRC-1:0] sync;
   genvar g;
   generate
      for (g = 0; g < SWK_NSRC; g++) begin : g_bit
         // first flop feeds only the second
         always_ff @(posedge mclk_i or posedge reset_i) begin
            if (reset_i) begin
               meta[g] <= 1'b0;
               sync[g] <= 1'b0;
            end else begin
               meta[g] <= raw_i[g];
               sync[g] <= meta[g];
            end
         end
         assign wake.level[g] = sync[g] ^ act_low_i[g];
      end
   endgenerate
endmodule : swk_sync

// >>> src/swk_qual.sv
// per-source qualification of wake levels by state and enables
`timescale 1ns/100ps
module swk_qual
   import swk_pkg::*;
(
   input wire logic [1:0] state_i,
   input wire logic [SWK_CTL_W-1:0] ctrl_i,
   input wire logic pci_armed_i,
   input wire logic lan_armed_i,
   swk_wake_if.dst wake,
   output logic [SWK_NSRC-1:0] qual_o
);
   logic s3;
   logic s35;
   logic s5;
   // s4 is never a target, so only s3 and s5 are sleep
   assign s3 = (state_i == SWK_ST_S3);
   assign s5 = (state_i == SWK_ST_S5);
   assign s35 = s3 | s5;
   assign qual_o[SWK_SRC_PWRBTN] = wake.level[SWK_SRC_PWRBTN] & s35;
   assign qual_o[SWK_SRC_SMBALR] = wake.level[SWK_SRC_SMBALR] & s35;
   assign qual_o[SWK_SRC_PCIEWK] = wake.level[SWK_SRC_PCIEWK] & s35;
   assign qual_o[SWK_SRC_WDTBTN] = wake.level[SWK_SRC_WDTBTN] & s35;
   assign qual_o[SWK_SRC_GENWK] = wake.level[SWK_SRC_GENWK] & s3;
   // pme gated by enable or armed device
   assign qual_o[SWK_SRC_PME] = wake.level[SWK_SRC_PME] & s35
      & (ctrl_i[SWK_CTL_PME_EN] | pci_armed_i);
   assign qual_o[SWK_SRC_LAN] = wake.level[SWK_SRC_LAN] & s35
      & ctrl_i[SWK_CTL_LAN_EN] & lan_armed_i;
   // usb from s3 with enable and standby power
   assign qual_o[SWK_SRC_USB] = wake.level[SWK_SRC_USB] & s3
      & ctrl_i[SWK_CTL_USB_EN] & ctrl_i[SWK_CTL_USB_SBY];
   // rtc alarm from s5 only, when enabled
   assign qual_o[SWK_SRC_RTC] = wake.level[SWK_SRC_RTC] & s5 & ctrl_i[SWK_CTL_RTC_EN];
endmodule : swk_qual

// >>> src/swk_top.sv
// top of the sleep wake event logic: registers, sequencer, interrupt
//
// Notes on behaviour
// - only s3 suspend-to-ram and s5 are sleep targets; s4 is never offered.
// - power button, smbus alert, pcie wake, watchdog button wake from s3 and s5.
// - general wake input resumes from s3 only.
// - pme resumes only with pme enable set or a device armed.
// - rtc alarm wakes only when enabled and only from s5.
// - usb wakes from s3 only with enable and standby power.
// - lan wakes only once the driver armed wake-on-lan.
// - names with low suffix are active low, the rest active high.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module swk_top
   import swk_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [1:0] sleep_state_i,
   input wire logic pwrbtn_n_i,
   input wire logic smb_alert_n_i,
   input wire logic pcie_wake_n_i,
   input wire logic wdt_btn_i,
   input wire logic gen_wake_n_i,
   input wire logic pme_n_i,
   input wire logic lan_wake_n_i,
   input wire logic usb_wake_i,
   input wire logic rtc_alarm_i,
   input wire logic pci_armed_i,
   input wire logic lan_armed_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic resume_o,
   output logic [SWK_NSRC-1:0] cause_o,
   output logic irq_o
);
   localparam logic [SWK_NSRC-1:0] ACT_LOW = 9'h077;
   logic [SWK_NSRC-1:0] raw;
   logic [SWK_NSRC-1:0] qual;
   logic [SWK_CTL_W-1:0] ctrl;
   logic [SWK_NSRC-1:0] status;
   logic [SWK_NSRC-1:0] mask;
   logic [SWK_NSRC-1:0] clr;
   logic [SWK_NSRC-1:0] hit;
   logic [1:0] st_meta;
   logic [1:0] st_sync;
   logic sleeping;
   swk_state_e state;
   swk_state_e next_state;
   swk_wake_if wake_bus ();

   // gather pins; polarity handled in sync
   assign raw = {rtc_alarm_i, usb_wake_i, lan_wake_n_i, pme_n_i, gen_wake_n_i,
                 wdt_btn_i, pcie_wake_n_i, smb_alert_n_i, pwrbtn_n_i};

   swk_sync u_sync (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .raw_i(raw),
      .act_low_i(ACT_LOW),
      .wake(wake_bus.src)
   );

   // sleep state from another domain, two flops
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_meta <= SWK_ST_S0;
         st_sync <= SWK_ST_S0;
      end else begin
         st_meta <= sleep_state_i;
         st_sync <= st_meta;
      end
   end

   swk_qual u_qual (
      .state_i(st_sync),
      .ctrl_i(ctrl),
      .pci_armed_i(pci_armed_i),
      .lan_armed_i(lan_armed_i),
      .wake(wake_bus.dst),
      .qual_o(qual)
   );

   // s4 not a recognised sleep state
   assign sleeping = (st_sync == SWK_ST_S3) || (st_sync == SWK_ST_S5);

   // sequencer: arm on sleep, one resume pulse, wait for s0
   always_comb begin
      next_state = state;
      case (state)
         SWK_IDLE: begin
            if (sleeping) begin
               next_state = SWK_ARMED;
            end
         end
         SWK_ARMED: begin
            if (!sleeping) begin
               next_state = SWK_IDLE;
            end else if (|qual) begin
               next_state = SWK_RESUME;
            end
         end
         SWK_RESUME: begin
            next_state = SWK_WAIT;
         end
         SWK_WAIT: begin
            // stays until power sequencing returns to s0, so no repeat pulse
            if (st_sync == SWK_ST_S0) begin
               next_state = SWK_IDLE;
            end
         end
         default: begin
            next_state = SWK_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= SWK_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign resume_o = (state == SWK_RESUME);

   assign hit = (state == SWK_ARMED && sleeping) ? qual : '0;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cause_o <= '0;
      end else if (state == SWK_ARMED && sleeping && |qual) begin
         cause_o <= qual;
      end
   end

   // write-one-to-clear; a new hit wins over the clear
   assign clr = (wr_i && addr_i == SWK_REG_STATUS) ? wdata_i[SWK_NSRC-1:0] : '0;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         status <= '0;
      end else begin
         status <= (status & ~clr) | hit;
      end
   end

   // control and mask writes
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl <= SWK_CTL_RST;
         mask <= SWK_MASK_RST;
      end else if (wr_i) begin
         if (addr_i == SWK_REG_CTRL) begin
            ctrl <= wdata_i[SWK_CTL_W-1:0];
         end
         if (addr_i == SWK_REG_MASK) begin
            mask <= wdata_i[SWK_NSRC-1:0];
         end
      end
   end

   // read data one cycle after strobe, zero otherwise and for unmapped
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            SWK_REG_CTRL: rdata_o <= {{(32-SWK_CTL_W){1'b0}}, ctrl};
            SWK_REG_STATUS: rdata_o <= {{(32-SWK_NSRC){1'b0}}, status};
            SWK_REG_MASK: rdata_o <= {{(32-SWK_NSRC){1'b0}}, mask};
            SWK_REG_STATE: rdata_o <= {28'h0000000, state, st_sync};
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   // level interrupt while any unmasked status bit set
   assign irq_o = |(status & mask);

   resume_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      resume_o |=> !resume_o)
      else $error("resume longer than one cycle");

   // status records the cause on resume
   cause_latch_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      resume_o |-> (cause_o != '0) && ((status & cause_o) == cause_o))
      else $error("cause not latched at resume");

   sleep_only_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      ($rose(resume_o)) |-> $past(sleeping))
      else $error("resume without sleep state");

   // general wake never causes from s5
   gen_s3_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (st_sync == SWK_ST_S5) |-> !qual[SWK_SRC_GENWK])
      else $error("general wake qualified outside s3");

   // rtc only from s5 with enable
   rtc_s5_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      qual[SWK_SRC_RTC] |-> (st_sync == SWK_ST_S5) && ctrl[SWK_CTL_RTC_EN])
      else $error("rtc wake not gated");

   // pme needs enable or armed device
   pme_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      qual[SWK_SRC_PME] |-> (ctrl[SWK_CTL_PME_EN] || pci_armed_i))
      else $error("pme wake not gated");

   // usb needs s3, enable and standby
   usb_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      qual[SWK_SRC_USB] |-> (st_sync == SWK_ST_S3) && ctrl[SWK_CTL_USB_EN]
         && ctrl[SWK_CTL_USB_SBY])
      else $error("usb wake not gated");

   lan_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      qual[SWK_SRC_LAN] |-> lan_armed_i && ctrl[SWK_CTL_LAN_EN])
      else $error("lan wake not gated");

   // asserted power button in armed sleep resumes next cycle
   pwrbtn_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && sleeping && wake_bus.level[SWK_SRC_PWRBTN]) |=> resume_o)
      else $error("power button did not resume");

   no_s4_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (st_sync == SWK_ST_S4) |-> (qual == '0))
      else $error("wake qualified in s4");

   // low level on active-low pin reads asserted after sync
   polarity_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!pwrbtn_n_i ##1 !pwrbtn_n_i ##1 !pwrbtn_n_i) |-> wake_bus.level[SWK_SRC_PWRBTN])
      else $error("active low pin not inverted");

   // smbus alert in armed sleep resumes next cycle
   smb_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && sleeping && wake_bus.level[SWK_SRC_SMBALR])
         |=> resume_o)
      else $error("smbus alert did not resume");

   // pcie wake in armed sleep resumes next cycle
   pcie_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && sleeping && wake_bus.level[SWK_SRC_PCIEWK])
         |=> resume_o)
      else $error("pcie wake did not resume");

   // watchdog button in armed sleep resumes next cycle
   wdt_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && sleeping && wake_bus.level[SWK_SRC_WDTBTN])
         |=> resume_o)
      else $error("watchdog button did not resume");

   // general wake in armed s3 resumes next cycle
   gen_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && st_sync == SWK_ST_S3 && wake_bus.level[SWK_SRC_GENWK])
         |=> resume_o)
      else $error("general wake did not resume from s3");

   // enabled rtc alarm in armed s5 resumes next cycle
   rtc_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && st_sync == SWK_ST_S5 && ctrl[SWK_CTL_RTC_EN]
         && wake_bus.level[SWK_SRC_RTC]) |=> resume_o)
      else $error("rtc alarm did not resume from s5");

   // running state never qualifies a wake
   run_quiet_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (st_sync == SWK_ST_S0) |-> (qual == '0))
      else $error("wake qualified while running");

   // wait holds until s0 is reached, so no second pulse
   wait_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_WAIT && st_sync != SWK_ST_S0) |=> (state == SWK_WAIT))
      else $error("sequencer left wait while still asleep");

   // a hit lands in status even beside a clear
   status_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (hit != '0) |=> ((status & $past(hit)) == $past(hit)))
      else $error("wake source not recorded in status");

   // cause takes the qualified sources of the wake cycle
   cause_take_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state == SWK_ARMED && sleeping && |qual) |=> (cause_o == $past(qual)))
      else $error("cause does not match qualified sources");

   cause_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      !(state == SWK_ARMED && sleeping && |qual) |=> $stable(cause_o))
      else $error("cause changed without a wake");

   // write-one-to-clear empties the written bits when no hit competes
   status_clr_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (clr != '0 && hit == '0) |=> ((status & $past(clr)) == '0))
      else $error("status bits not cleared by write");
endmodule : swk_top

// >>> tb/swk_partner.sv
// partner model: wake sources and power sequencing around the wake logic
`timescale 1ns/100ps
module swk_partner
   import swk_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [SWK_NSRC-1:0] assert_i,
   input wire logic enter_i,
   input wire logic [1:0] target_i,
   input wire logic resume_i,
   output logic [SWK_NSRC-1:0] pins_o,
   output logic [1:0] sleep_state_o
);
   // pins with a low suffix idle high, the rest idle low
   localparam logic [SWK_NSRC-1:0] LOW_PINS = 9'h077;
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pins_o <= LOW_PINS;
      end else begin
         pins_o <= assert_i ^ LOW_PINS;
      end
   end
   // sequencing returns to s0 on resume; a resume beats a sleep request
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sleep_state_o <= SWK_ST_S0;
      end else if (resume_i) begin
         sleep_state_o <= SWK_ST_S0;
      end else if (enter_i) begin
         sleep_state_o <= target_i;
      end
   end
endmodule : swk_partner

// >>> tb/swk_top_tb_top.sv
// self-checking bench for the sleep wake event logic
`timescale 1ns/100ps
module swk_top_tb_top;
   import swk_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic pci_armed_i = 1'b0;
   logic lan_armed_i = 1'b0;
   logic [SWK_NSRC-1:0] asrt = 9'h000;
   logic enter = 1'b0;
   logic [1:0] target = SWK_ST_S0;
   logic [SWK_NSRC-1:0] pins;
   logic [1:0] sleep_state;
   logic [31:0] rdata_o;
   logic resume_o;
   logic [SWK_NSRC-1:0] cause_o;
   logic irq_o;
   logic [SWK_NSRC-1:0] mask = 9'h000;
   int error_cnt = 0;
   int cmp_count = 0;
   // control bits
   localparam logic [4:0] CP = 5'h01 << SWK_CTL_PME_EN;
   localparam logic [4:0] CR = 5'h01 << SWK_CTL_RTC_EN;
   localparam logic [4:0] CU = 5'h01 << SWK_CTL_USB_EN;
   localparam logic [4:0] CS = 5'h01 << SWK_CTL_USB_SBY;
   localparam logic [4:0] CL = 5'h01 << SWK_CTL_LAN_EN;

   always #25 mclk_i = ~mclk_i;

   swk_partner partner (.mclk_i(mclk_i), .reset_i(reset_i), .assert_i(asrt), .enter_i(enter),
      .target_i(target), .resume_i(resume_o), .pins_o(pins), .sleep_state_o(sleep_state));
   swk_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .sleep_state_i(sleep_state),
      .pwrbtn_n_i(pins[SWK_SRC_PWRBTN]), .smb_alert_n_i(pins[SWK_SRC_SMBALR]),
      .pcie_wake_n_i(pins[SWK_SRC_PCIEWK]), .wdt_btn_i(pins[SWK_SRC_WDTBTN]),
      .gen_wake_n_i(pins[SWK_SRC_GENWK]), .pme_n_i(pins[SWK_SRC_PME]),
      .lan_wake_n_i(pins[SWK_SRC_LAN]), .usb_wake_i(pins[SWK_SRC_USB]),
      .rtc_alarm_i(pins[SWK_SRC_RTC]), .pci_armed_i(pci_armed_i), .lan_armed_i(lan_armed_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .resume_o(resume_o), .cause_o(cause_o), .irq_o(irq_o));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      chk(what, exp, rdata_o);
   endtask : rd_chk

   task automatic go_state(input logic [1:0] st);
      @(posedge mclk_i);
      enter <= 1'b1;
      target <= st;
      @(posedge mclk_i);
      enter <= 1'b0;
      repeat (6) @(posedge mclk_i);
   endtask : go_state

   // one wake attempt: count resume pulses, then check cause, status, irq
   task automatic try_wake(input int src, input logic [1:0] st, input logic [4:0] ctl,
         input logic pci, input logic lan, input logic exp);
      logic [SWK_NSRC-1:0] bit_v;
      logic [SWK_NSRC-1:0] seen;
      logic sleeping;
      int pulses;
      bit_v = 9'h001 << src;
      seen = 9'h000;
      pulses = 0;
      sleeping = (st == SWK_ST_S3) || (st == SWK_ST_S5);
      wr_reg(SWK_REG_CTRL, {27'h0, ctl});
      wr_reg(SWK_REG_MASK, {23'h0, mask});
      pci_armed_i <= pci;
      lan_armed_i <= lan;
      go_state(st);
      // armed sequencer reads 01 in the upper pair, idle reads 00
      rd_chk(SWK_REG_STATE, {28'h0, 1'b0, sleeping, st}, "state reg");
      @(posedge mclk_i);
      asrt <= bit_v;
      repeat (12) begin
         @(negedge mclk_i);
         if (resume_o === 1'b1) begin
            pulses++;
            seen = cause_o;
         end
      end
      chk("resume pulses", {31'h0, exp}, pulses);
      chk("cause", exp ? bit_v : 9'h000, seen);
      @(posedge mclk_i);
      asrt <= 9'h000;
      go_state(SWK_ST_S0);
      rd_chk(SWK_REG_STATUS, exp ? bit_v : 9'h000, "status");
      chk("irq set", exp & mask[src], irq_o);
      wr_reg(SWK_REG_STATUS, {23'h0, bit_v});
      rd_chk(SWK_REG_STATUS, 32'h0, "status clr");
      chk("irq clr", 1'b0, irq_o);
   endtask : try_wake

   task automatic t_reset();
      chk("outs", 11'h000, {resume_o, irq_o, cause_o});
      rd_chk(SWK_REG_CTRL, 32'h0, "ctrl rst");
      rd_chk(SWK_REG_MASK, 32'h0, "mask rst");
      rd_chk(SWK_REG_STATUS, 32'h0, "status rst");
      wr_reg(4'h2, 32'hFFFFFFFF);
      wr_reg(SWK_REG_STATE, 32'hFFFFFFFF);
      rd_chk(4'h2, 32'h0, "unmapped");
      rd_chk(SWK_REG_STATE, 32'h0, "state ro");
      rd_chk(SWK_REG_CTRL, 32'h0, "ctrl kept");
      wr_reg(SWK_REG_MASK, 32'hFFFFFFFF);
      rd_chk(SWK_REG_MASK, 32'h1FF, "mask rw");
      $display("test reset done");
   endtask : t_reset

   task automatic t_uncond();
      logic [1:0] sts [4] = '{SWK_ST_S3, SWK_ST_S4, SWK_ST_S5, SWK_ST_S0};
      for (int s = 0; s < 4; s++) begin
         foreach (sts[i]) begin
            try_wake(s, sts[i], 5'h00, 1'b0, 1'b0, i == 0 || i == 2);
         end
      end
      $display("test uncond done");
   endtask : t_uncond

   task automatic t_gated();
      try_wake(SWK_SRC_GENWK, SWK_ST_S3, 5'h00, 1'b0, 1'b0, 1'b1);
      try_wake(SWK_SRC_GENWK, SWK_ST_S5, 5'h00, 1'b0, 1'b0, 1'b0);
      try_wake(SWK_SRC_PME, SWK_ST_S3, 5'h1E, 1'b0, 1'b1, 1'b0);
      try_wake(SWK_SRC_PME, SWK_ST_S3, CP, 1'b0, 1'b0, 1'b1);
      try_wake(SWK_SRC_PME, SWK_ST_S5, 5'h00, 1'b1, 1'b0, 1'b1);
      try_wake(SWK_SRC_RTC, SWK_ST_S5, CR, 1'b0, 1'b0, 1'b1);
      try_wake(SWK_SRC_RTC, SWK_ST_S5, 5'h1D, 1'b1, 1'b1, 1'b0);
      try_wake(SWK_SRC_RTC, SWK_ST_S3, CR, 1'b0, 1'b0, 1'b0);
      try_wake(SWK_SRC_USB, SWK_ST_S3, CU | CS, 1'b0, 1'b0, 1'b1);
      try_wake(SWK_SRC_USB, SWK_ST_S3, CU, 1'b0, 1'b0, 1'b0);
      try_wake(SWK_SRC_USB, SWK_ST_S3, CS, 1'b0, 1'b0, 1'b0);
      try_wake(SWK_SRC_USB, SWK_ST_S5, CU | CS, 1'b0, 1'b0, 1'b0);
      try_wake(SWK_SRC_LAN, SWK_ST_S3, CL, 1'b0, 1'b1, 1'b1);
      try_wake(SWK_SRC_LAN, SWK_ST_S3, CL, 1'b0, 1'b0, 1'b0);
      try_wake(SWK_SRC_LAN, SWK_ST_S5, 5'h0F, 1'b1, 1'b1, 1'b0);
      $display("test gated done");
   endtask : t_gated

   // interrupt follows status only where the mask lets it through
   task automatic t_irq();
      mask = 9'h1FF;
      try_wake(SWK_SRC_WDTBTN, SWK_ST_S3, 5'h00, 1'b0, 1'b0, 1'b1);
      mask = 9'h1F7;
      try_wake(SWK_SRC_WDTBTN, SWK_ST_S5, 5'h00, 1'b0, 1'b0, 1'b1);
      mask = 9'h000;
      $display("test irq done");
   endtask : t_irq

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (16) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_reset();
      t_uncond();
      t_gated();
      t_irq();
      close_out();
   end

   // about 1400 cycles expected; generous margin against a hang
   initial begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      $display("watchdog expired");
      close_out();
   end
endmodule : swk_top_tb_top
